// file: core/spm_defs.svh
// Purpose: shared constants of the serial pin control block
// Assumes: included by its bare name from package and modules
// Notes: the register index is kept; the byte address is four times it
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// register index and byte address of the serial pin control register
`define SPM_CTRL_IDX 32'h0000ff91
`define SPM_CTRL_ADDR (`SPM_CTRL_IDX * 32'h00000004)

// reset value and the two reserved bits that always read one
`define SPM_CTRL_RST 8'hc0
`define SPM_RSVD_MASK 8'hc0

// field positions
`define SPM_B_CHAN2_SEL 5
`define SPM_B_CHAN1_SEL 4
`define SPM_B_CHAN2_TX_INV 3
`define SPM_B_CHAN2_RX_INV 2
`define SPM_B_CHAN1_TX_INV 1
`define SPM_B_CHAN1_RX_INV 0

// depth of the pin input synchroniser
`define SPM_SYNC_STAGES 3

`endif

// file: core/spm_pkg.sv
// Purpose: types of the serial pin control block
// Assumes: constants come from spm_defs.svh
// Notes: field layout mirrors the control register bit order
`include "spm_defs.svh"
package spm_pkg;
    // pin function picked by a select bit
    typedef enum logic {SPM_FN_PORT, SPM_FN_TX} spm_pin_fn_e;

    // control register layout, bit 7 first
    typedef struct packed {
        logic [1:0] rsvd;
        logic chan2_tx_pin_select;
        logic chan1_tx_pin_select;
        logic chan2_tx_invert;
        logic chan2_rx_invert;
        logic chan1_tx_invert;
        logic chan1_rx_invert;
    } spm_ctrl_s;

    typedef logic [7:0] spm_byte_t;
endpackage

// file: core/spm_reg_if.sv
// Purpose: carrier between the bus slave and the control register
// Assumes: one clock domain
// Notes: wr_stb is a one-cycle pulse at the completing bus edge
`timescale 1ns/10ps
`default_nettype none
interface spm_reg_if;
    logic wr_stb;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus (output wr_stb, output wdata, input rdata);
    modport regs (input wr_stb, input wdata, output rdata);
endinterface
`default_nettype wire

// file: core/spm_apb_slave.sv
// Purpose: apb slave in front of the single control register
// Assumes: pclk at 50 MHz, asynchronous active-low presetn
// Notes: one wait state per access; unmapped addresses answer pslverr
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"
module spm_apb_slave (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // register side
    spm_reg_if.bus regs
);
    import spm_pkg::*;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // decode: only the one aligned word is mapped
    wire addr_hit = (paddr == `SPM_CTRL_ADDR);
    wire acc_first = psel && penable && !pready_q;
    wire acc_done = psel && penable && pready_q;

    // the write lands only at the edge where pready is sampled high
    assign regs.wr_stb = acc_done && pwrite && addr_hit && pstrb[0];
    assign regs.wdata = pwdata[7:0];

    // answer one cycle into the access phase, so prdata, pready and pslverr are flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= acc_first;
            pslverr_q <= acc_first && !addr_hit;
            prdata_q <= (acc_first && !pwrite && addr_hit) ? {24'h000000, regs.rdata} : 32'h00000000;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
endmodule
`default_nettype wire

// file: core/spm_pin_mux.sv
// Purpose: transmit pin function select and serial data inversion, two channels
// Assumes: pclk at 50 MHz; receive pins are asynchronous to pclk
// Notes: inversion paths are pure gates, so pin outputs are not registered
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"
module spm_pin_mux (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial interface side
    input wire logic chan1_txd,
    input wire logic chan2_txd,
    output logic chan1_rxd,
    output logic chan2_rxd,
    output logic chan1_tx_pin_select,
    output logic chan2_tx_pin_select,
    // general port side
    input wire logic port3_bit5_out,
    input wire logic port3_bit5_oe_n,
    output logic port3_bit5_in,
    input wire logic port4_bit2_out,
    input wire logic port4_bit2_oe_n,
    output logic port4_bit2_in,
    // receive pins
    input wire logic chan1_rx_pin,
    input wire logic chan2_rx_pin,
    // shared transmit / port pins
    input wire logic chan1_tx_pin_in,
    output logic chan1_tx_pin_out,
    output logic chan1_tx_pin_oe_n,
    input wire logic chan2_tx_pin_in,
    output logic chan2_tx_pin_out,
    output logic chan2_tx_pin_oe_n
);
    import spm_pkg::*;

    spm_reg_if reg_bus ();
    spm_ctrl_s ctrl_q;
    spm_ctrl_s ctrl_d;

    // bus slave answers over the carrier
    spm_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .regs(reg_bus.bus)
    );

    // reserved bits are forced so no write can clear them
    assign ctrl_d = reg_bus.wr_stb ? spm_ctrl_s'(reg_bus.wdata | `SPM_RSVD_MASK) : ctrl_q;
    assign reg_bus.rdata = ctrl_q | `SPM_RSVD_MASK;

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= spm_ctrl_s'(`SPM_CTRL_RST);
        else
            ctrl_q <= ctrl_d;
    end

    // pin inputs: rx pins and the pad side of the shared tx pins
    wire [3:0] pin_raw = {chan2_tx_pin_in, chan1_tx_pin_in, chan2_rx_pin, chan1_rx_pin};
    wire [3:0] pin_stable_q;

    // three sync flops and one hold flop per pin; a level counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            logic [`SPM_SYNC_STAGES-1:0] sync_q;
            logic stable_q;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync_q <= '0;
                    stable_q <= 1'b0;
                end
                else
                begin
                    sync_q <= {sync_q[1:0], pin_raw[gi]};
                    if (sync_q[1] == sync_q[2])
                        stable_q <= sync_q[2];
                end
            end
            // each lane owns its own flop, so no two processes write one vector
            assign pin_stable_q[gi] = stable_q;
        end
    endgenerate

    // receive inversion: gates only, so a control write shows at once
    assign chan1_rxd = pin_stable_q[0] ^ ctrl_q.chan1_rx_invert;
    assign chan2_rxd = pin_stable_q[1] ^ ctrl_q.chan2_rx_invert;

    // port logic reads the pad back whatever the function
    assign port3_bit5_in = pin_stable_q[2];
    assign port4_bit2_in = pin_stable_q[3];

    // transmit inversion, again with no register in the path
    wire chan1_tx_data = chan1_txd ^ ctrl_q.chan1_tx_invert;
    wire chan2_tx_data = chan2_txd ^ ctrl_q.chan2_tx_invert;

    // function select; the transmitter owns the pad when selected
    wire chan1_fn_tx = (spm_pin_fn_e'(ctrl_q.chan1_tx_pin_select) == SPM_FN_TX);
    wire chan2_fn_tx = (spm_pin_fn_e'(ctrl_q.chan2_tx_pin_select) == SPM_FN_TX);
    assign chan1_tx_pin_out = chan1_fn_tx ? chan1_tx_data : port3_bit5_out;
    assign chan1_tx_pin_oe_n = chan1_fn_tx ? 1'b0 : port3_bit5_oe_n;
    assign chan2_tx_pin_out = chan2_fn_tx ? chan2_tx_data : port4_bit2_out;
    assign chan2_tx_pin_oe_n = chan2_fn_tx ? 1'b0 : port4_bit2_oe_n;

    // the serial interface may gate its enable on these; it relies on software order
    assign chan1_tx_pin_select = ctrl_q.chan1_tx_pin_select;
    assign chan2_tx_pin_select = ctrl_q.chan2_tx_pin_select;

    // checks

    property p_reset_value;
        @(posedge pclk) $rose(presetn) |-> (ctrl_q == `SPM_CTRL_RST);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("control not c0 after reset");

    property p_rsvd_read;
        @(posedge pclk) disable iff (!presetn)
        reg_bus.wr_stb |=> (reg_bus.rdata[7:6] == 2'b11) [*2];
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not read as one");

    property p_chan2_sel;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.chan2_tx_pin_select |-> !chan2_tx_pin_oe_n && (chan2_tx_pin_out == chan2_tx_data);
    endproperty
    a_chan2_sel: assert property (p_chan2_sel) else $error("chan2 pin not driven by transmitter");

    property p_chan1_port;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_q.chan1_tx_pin_select |-> (chan1_tx_pin_out == port3_bit5_out) && (chan1_tx_pin_oe_n == port3_bit5_oe_n);
    endproperty
    a_chan1_port: assert property (p_chan1_port) else $error("chan1 pin not owned by port");

    property p_chan2_tx_inv;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.chan2_tx_pin_select |-> (chan2_tx_pin_out == (chan2_txd ^ ctrl_q[`SPM_B_CHAN2_TX_INV]));
    endproperty
    a_chan2_tx_inv: assert property (p_chan2_tx_inv) else $error("chan2 tx inversion wrong");

    property p_chan2_rx_inv;
        @(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q[`SPM_B_CHAN2_RX_INV]) && $stable(pin_stable_q[1]) |-> (chan2_rxd != $past(chan2_rxd));
    endproperty
    a_chan2_rx_inv: assert property (p_chan2_rx_inv) else $error("chan2 rx inversion wrong");

    property p_chan1_tx_inv;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.chan1_tx_pin_select && ctrl_q.chan1_tx_invert |-> (chan1_tx_pin_out == !chan1_txd);
    endproperty
    a_chan1_tx_inv: assert property (p_chan1_tx_inv) else $error("chan1 tx inversion wrong");

    property p_chan1_rx_inv;
        @(posedge pclk) disable iff (!presetn)
        chan1_rxd == (pin_stable_q[0] ^ ctrl_q[`SPM_B_CHAN1_RX_INV]);
    endproperty
    a_chan1_rx_inv: assert property (p_chan1_rx_inv) else $error("chan1 rx inversion wrong");

    sequence s_inv_write;
        reg_bus.wr_stb && (reg_bus.wdata[`SPM_B_CHAN1_RX_INV] != ctrl_q.chan1_rx_invert) && $stable(pin_stable_q[0]);
    endsequence
    sequence s_rx_flipped;
        ##1 (chan1_rxd != $past(chan1_rxd)) || (pin_stable_q[0] != $past(pin_stable_q[0]));
    endsequence
    property p_inv_immediate;
        @(posedge pclk) disable iff (!presetn)
        s_inv_write |-> s_rx_flipped;
    endproperty
    a_inv_immediate: assert property (p_inv_immediate) else $error("inversion change not seen next cycle");

    property p_xor_no_delay;
        @(posedge pclk) disable iff (!presetn)
        $changed(chan2_txd) && $stable(ctrl_q) && ctrl_q.chan2_tx_pin_select |-> $changed(chan2_tx_pin_out);
    endproperty
    a_xor_no_delay: assert property (p_xor_no_delay) else $error("tx path has register delay");

    property p_chan2_port;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_q.chan2_tx_pin_select |-> (chan2_tx_pin_out == port4_bit2_out) && (chan2_tx_pin_oe_n == port4_bit2_oe_n);
    endproperty
    a_chan2_port: assert property (p_chan2_port) else $error("chan2 pin not owned by port");

    property p_chan1_sel;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.chan1_tx_pin_select |-> !chan1_tx_pin_oe_n && (chan1_tx_pin_out == (chan1_txd ^ ctrl_q.chan1_tx_invert));
    endproperty
    a_chan1_sel: assert property (p_chan1_sel) else $error("chan1 pin not driven by transmitter");

    // a write to the select bits must show on the exported selects one edge later
    property p_sel_write;
        @(posedge pclk) disable iff (!presetn)
        reg_bus.wr_stb |=> (chan2_tx_pin_select == $past(reg_bus.wdata[`SPM_B_CHAN2_SEL]))
            && (chan1_tx_pin_select == $past(reg_bus.wdata[`SPM_B_CHAN1_SEL]));
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select bits not taken from write");
endmodule
`default_nettype wire

// file: verification/spm_serial_peer.sv
// Purpose: far serial device on the receive and shared transmit pads
// Assumes: one clock; levels to send are chosen by the bench
// Notes: the far side drives a shared pad only while the block has released it
`timescale 1ns/10ps
`default_nettype none
module spm_serial_peer (
    // clock
    input wire logic pclk,
    // levels the far device puts out
    input wire logic [1:0] rx_lvl,
    input wire logic [1:0] far_lvl,
    // pad drive from the block
    input wire logic [1:0] tx_out,
    input wire logic [1:0] tx_oe_n,
    // pads seen by the block
    output logic [1:0] rx_pin,
    output logic [1:0] tx_in
);
    // receive levels change just after an edge, never on it
    always_ff @(posedge pclk)
    begin
        rx_pin <= rx_lvl;
    end

    // wired pad: the block wins while its enable is low, else the far side drives
    assign tx_in = (~tx_oe_n & tx_out) | (tx_oe_n & far_lvl);
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench for the serial pin mux
// Assumes: apb answers after a wait; pins settle within 8 cycles
// Notes: pins are checked just after each write edge and again once synced
`timescale 1ns/10ps
`default_nettype none
`include "spm_defs.svh"
module tb_top;
    import spm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, d;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] txd = 2'h0, pout = 2'h0, poe_n = 2'h3, rx_lvl = 2'h0, far_lvl = 2'h0;
    logic [1:0] rxd, sel, tout, toe_n, tin, rxp, pin_in;
    logic [7:0] ctrl = 8'hc0;
    int n_errors = 0, samples_checked = 0, cyc = 0;

    spm_pin_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan1_txd(txd[0]), .chan2_txd(txd[1]),
        .chan1_rxd(rxd[0]), .chan2_rxd(rxd[1]), .chan1_tx_pin_select(sel[0]),
        .chan2_tx_pin_select(sel[1]), .port3_bit5_out(pout[0]), .port3_bit5_oe_n(poe_n[0]),
        .port3_bit5_in(pin_in[0]), .port4_bit2_out(pout[1]), .port4_bit2_oe_n(poe_n[1]),
        .port4_bit2_in(pin_in[1]), .chan1_rx_pin(rxp[0]), .chan2_rx_pin(rxp[1]),
        .chan1_tx_pin_in(tin[0]), .chan1_tx_pin_out(tout[0]), .chan1_tx_pin_oe_n(toe_n[0]),
        .chan2_tx_pin_in(tin[1]), .chan2_tx_pin_out(tout[1]), .chan2_tx_pin_oe_n(toe_n[1]));

    spm_serial_peer u_peer (.pclk(pclk), .rx_lvl(rx_lvl), .far_lvl(far_lvl), .tx_out(tout),
        .tx_oe_n(toe_n), .rx_pin(rxp), .tx_in(tin));

    // clock and hang guard
    always #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s exp %0b got %0b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // selected pin carries transmit data through the invert bit, else the port drive
    function automatic logic exp_tx(input logic s, input logic inv, input logic t, input logic p);
        return s ? (t ^ inv) : p;
    endfunction

    task automatic chk_pins(input logic synced);
        chk_bit("sel1", ctrl[4], sel[0]);
        chk_bit("sel2", ctrl[5], sel[1]);
        chk_bit("tx1_out", exp_tx(ctrl[4], ctrl[1], txd[0], pout[0]), tout[0]);
        chk_bit("tx2_out", exp_tx(ctrl[5], ctrl[3], txd[1], pout[1]), tout[1]);
        chk_bit("tx1_oe_n", exp_tx(ctrl[4], 1'b0, 1'b0, poe_n[0]), toe_n[0]);
        chk_bit("tx2_oe_n", exp_tx(ctrl[5], 1'b0, 1'b0, poe_n[1]), toe_n[1]);
        chk_bit("rx1", rx_lvl[0] ^ ctrl[0], rxd[0]);
        chk_bit("rx2", rx_lvl[1] ^ ctrl[2], rxd[1]);
        if (synced)
        begin
            chk_bit("port3_bit5_in", exp_tx(ctrl[4], ctrl[1], txd[0], poe_n[0] ? far_lvl[0] : pout[0]), pin_in[0]);
            chk_bit("port4_bit2_in", exp_tx(ctrl[5], ctrl[3], txd[1], poe_n[1] ? far_lvl[1] : pout[1]), pin_in[1]);
        end
    endtask

    // reset, corner accesses, then random settings with mid-bit changes
    initial
    begin
        void'($urandom(32'hed13));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SPM_CTRL_ADDR, 32'h0, 4'h0, rd, err);
        chk_word("ctrl_reset", 32'hc0, rd);
        chk_pins(1'b1);
        apb(1'b1, 32'h0, 32'h3f, 4'hf, rd, err);
        chk_bit("slverr_wr", 1'b1, err);
        apb(1'b0, 32'h0, 32'h0, 4'h0, rd, err);
        chk_bit("slverr_rd", 1'b1, err);
        chk_word("unmapped_rd", 32'h0, rd);
        apb(1'b1, `SPM_CTRL_ADDR, 32'h3f, 4'h0, rd, err);
        apb(1'b0, `SPM_CTRL_ADDR, 32'h0, 4'h0, rd, err);
        chk_word("ctrl_nostrb", 32'hc0, rd);
        for (int i = 0; i < 24; i++)
        begin
            d = $urandom;
            if (i == 0)
                d = 32'h0000ff3f;
            if (i == 1)
                d = 32'h00000000;
            // pads and data stand still across the write, so the level jump is harmless
            apb(1'b1, `SPM_CTRL_ADDR, d, 4'h1, rd, err);
            chk_bit("ok_wr", 1'b0, err);
            ctrl = d[7:0] | 8'hc0;
            #1;
            chk_pins(1'b0);
            apb(1'b0, `SPM_CTRL_ADDR, 32'h0, 4'h0, rd, err);
            chk_word("ctrl_rd", {24'h0, ctrl}, rd);
            chk_bit("ok_rd", 1'b0, err);
            // transmit data only moves once the select write above has landed
            txd <= 2'($urandom);
            pout <= 2'($urandom);
            poe_n <= 2'($urandom);
            rx_lvl <= 2'($urandom);
            far_lvl <= 2'($urandom);
            // the pad must follow new transmit data within the same cycle
            #1;
            chk_bit("tx1_now", exp_tx(ctrl[4], ctrl[1], txd[0], pout[0]), tout[0]);
            chk_bit("tx2_now", exp_tx(ctrl[5], ctrl[3], txd[1], pout[1]), tout[1]);
            repeat (8) @(posedge pclk);
            #1;
            chk_pins(1'b1);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ctrl = 8'hc0;
        apb(1'b0, `SPM_CTRL_ADDR, 32'h0, 4'h0, rd, err);
        chk_word("ctrl_rereset", 32'hc0, rd);
        repeat (8) @(posedge pclk);
        #1;
        chk_pins(1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
